// file: src/uvps_top.v
// three-stage definite-time undervoltage protection with register port
// Operation
// - start when smallest line-to-line voltage drops below the stage pick-up
// - trip once undervoltage persisted beyond the stage operate delay
// - external block input per stage suppresses operation
// - stage self-blocked while largest line voltage is below block limit
// - block limit of zero disables the self-blocking
// - three separately configured definite-time stages
// - four setting groups, selected by input or manually, group reported
// - group source: none, digital, virtual, indicator, virtual output, key
// - each stage reports idle, blocked, started or tripped
// - per-stage start and trip counters, clearable by software
// - one shared force flag, cleared automatically after five minutes
// - start and trip values writable only while force flag set
// - configuration writes need an active password authorisation
// - first stage alone has a release delay holding its outputs
// - minimum line voltage readout in primary volts
// - pick-up level also reported as primary-side value
`include "uvps_map.vh"
module uvps_top #(
  parameter [31:0] MS_CYCLES = `UVPS_CLK_HZ / `UVPS_TICK_HZ,
  parameter [31:0] FORCE_MS  = `UVPS_FORCE_MIN * 60 * `UVPS_TICK_HZ,
  parameter [31:0] PASS_KEY  = 32'h00005A5A  // arbitrary value
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata,
  input  wire [15:0] u12,
  input  wire [15:0] u23,
  input  wire [15:0] u31,
  input  wire [2:0]  block_in,
  input  wire [1:0]  digital_input_source,
  input  wire [1:0]  virtual_input_source,
  input  wire [1:0]  indicator_source,
  input  wire [1:0]  virtual_output_source,
  input  wire [1:0]  function_key_source,
  output reg  [2:0]  start,
  output reg  [2:0]  trip,
  output reg  [1:0]  active_setting_group
);

  function [15:0] min2;
    input [15:0] a;
    input [15:0] b;
    begin
      min2 = (a < b) ? a : b;
    end
  endfunction

  function [15:0] max2;
    input [15:0] a;
    input [15:0] b;
    begin
      max2 = (a > b) ? a : b;
    end
  endfunction

  function [3:0] cidx;
    input [1:0] g;
    input [1:0] s;
    begin
      cidx = ({2'b00, g} << 1) + {2'b00, g} + {2'b00, s};
    end
  endfunction

  // percent-of-nominal to primary volts, scale is volts per unit
  function [31:0] prim;
    input [15:0] v;
    input [15:0] k;
    begin
      prim = {16'h0000, v} * {16'h0000, k};
    end
  endfunction

  reg  [15:0] pick [0:`UVPS_N_CFG-1];
  reg  [15:0] dly  [0:`UVPS_N_CFG-1];
  reg  [15:0] low_voltage_block_limit;
  reg  [15:0] hyst;
  reg  [15:0] hold;
  reg  [15:0] scale;
  reg  [2:0]  group_select_source;
  reg  [1:0]  manual_group;
  reg         auth;
  reg         force_on;
  reg  [18:0] force_ms;
  reg  [2:0]  fstart;
  reg  [2:0]  ftrip;
  reg  [31:0] ms_cnt;
  reg         tick;
  reg  [9:0]  gs1;
  reg  [9:0]  gs2;
  reg  [9:0]  gs3;
  reg  [9:0]  gsel;
  reg  [15:0] tmr [0:2];
  reg  [15:0] hold_cnt;
  reg  [2:0]  st_start;
  reg  [2:0]  st_trip;
  reg  [15:0] start_event_count [0:2];
  reg  [15:0] trip_event_count  [0:2];
  reg  [31:0] min_line_voltage_readout;
  reg  [2:0]  under;
  reg  [2:0]  blk;
  reg  [2:0]  expired;
  reg  [1:0]  next_group;
  reg  [2:0]  next_start;
  reg  [2:0]  next_trip;
  reg  [31:0] next_rdata;
  reg  [16:0] rel_lvl;
  reg  [15:0] p;
  wire [15:0] umin = min2(min2(u12, u23), u31);
  wire [15:0] umax = max2(max2(u12, u23), u31);
  wire        lv_blk = (low_voltage_block_limit != 16'h0000) && (umax < low_voltage_block_limit);
  wire        cfg_wr = wr && auth;
  wire        fval_wr = wr && (addr == `UVPS_A_FVAL) && force_on;
  wire [2:0]  cond = under & ~blk;
  integer     i;
  integer     j;
  integer     k;
  integer     n;

  // stage comparators and group choice
  always @* begin
    rel_lvl = 17'h00000;
    p = 16'h0000;
    for (i = 0; i < 3; i = i + 1) begin
      p = pick[cidx(active_setting_group, i[1:0])];
      rel_lvl = {1'b0, p} + {1'b0, hyst};
      blk[i] = block_in[i] | lv_blk;
      if (st_start[i]) begin
        under[i] = {1'b0, umin} <= rel_lvl;
      end else begin
        under[i] = umin < p;
      end
      expired[i] = tmr[i] >= dly[cidx(active_setting_group, i[1:0])];
    end
    case (group_select_source)
      `UVPS_SRC_DI:  next_group = gsel[1:0];
      `UVPS_SRC_VI:  next_group = gsel[3:2];
      `UVPS_SRC_LED: next_group = gsel[5:4];
      `UVPS_SRC_VO:  next_group = gsel[7:6];
      `UVPS_SRC_FK:  next_group = gsel[9:8];
      default:       next_group = manual_group;
    endcase
    next_start = force_on ? fstart : st_start;
    next_trip = force_on ? ftrip : st_trip;
  end

  // register read decode
  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `UVPS_A_PASS:   next_rdata = {31'h00000000, auth};
      `UVPS_A_FORCE:  next_rdata = {31'h00000000, force_on};
      `UVPS_A_FVAL:   next_rdata = {26'h0000000, trip, start};
      `UVPS_A_GRP:    next_rdata = {21'h000000,
                                    {1'b0, active_setting_group} + 3'h1,
                                    2'h0, manual_group, 1'b0,
                                    group_select_source};
      `UVPS_A_LOW_VOLTAGE_BLOCK_LIMIT:  next_rdata = {16'h0000, low_voltage_block_limit};
      `UVPS_A_HYST:   next_rdata = {16'h0000, hyst};
      `UVPS_A_HOLD:   next_rdata = {16'h0000, hold};
      `UVPS_A_SCALE:  next_rdata = {16'h0000, scale};
      `UVPS_A_STATUS: begin
        for (j = 0; j < 3; j = j + 1) begin
          next_rdata[2*j +: 2] = trip[j] ? `UVPS_ST_TRIPPED :
                                 start[j] ? `UVPS_ST_STARTED :
                                 blk[j] ? `UVPS_ST_BLOCKED : `UVPS_ST_IDLE;
        end
      end
      `UVPS_A_MIN_LINE_VOLTAGE_READOUT:   next_rdata = min_line_voltage_readout;
      default: begin
        for (j = 0; j < 3; j = j + 1) begin
          if (addr == `UVPS_A_SCNT + 8'h04 * j[7:0])
            next_rdata = {16'h0000, start_event_count[j]};
          if (addr == `UVPS_A_TCNT + 8'h04 * j[7:0])
            next_rdata = {16'h0000, trip_event_count[j]};
          if (addr == `UVPS_A_PPRIM + 8'h04 * j[7:0])
            next_rdata = prim(pick[cidx(active_setting_group, j[1:0])],
                              scale);
        end
        for (j = 0; j < `UVPS_N_CFG; j = j + 1) begin
          if (addr == `UVPS_A_PICK + 8'h04 * j[7:0])
            next_rdata = {16'h0000, pick[j]};
          if (addr == `UVPS_A_DLY + 8'h04 * j[7:0])
            next_rdata = {16'h0000, dly[j]};
        end
      end
    endcase
  end

  // bus registers, force flag, tick and input filters
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (k = 0; k < `UVPS_N_CFG; k = k + 1) begin
        pick[k] <= `UVPS_RST_PICK;
        dly[k] <= `UVPS_RST_DLY;
      end
      low_voltage_block_limit <= `UVPS_RST_LOW_VOLTAGE_BLOCK_LIMIT;
      hyst <= `UVPS_RST_HYST;
      hold <= `UVPS_RST_HOLD;
      scale <= `UVPS_RST_SCALE;
      group_select_source <= `UVPS_SRC_NONE;
      manual_group <= 2'h0;
      auth <= 1'b0;
      force_on <= 1'b0;
      force_ms <= 19'h00000;
      fstart <= 3'h0;
      ftrip <= 3'h0;
      ms_cnt <= 32'h00000000;
      tick <= 1'b0;
      gs1 <= 10'h000;
      gs2 <= 10'h000;
      gs3 <= 10'h000;
      gsel <= 10'h000;
      rdata <= 32'h00000000;
      active_setting_group <= 2'h0;
      min_line_voltage_readout <= 32'h00000000;
    end else if (ce) begin
      tick <= (ms_cnt == MS_CYCLES - 32'h1);
      ms_cnt <= (ms_cnt == MS_CYCLES - 32'h1) ? 32'h0 : ms_cnt + 32'h1;
      gs1 <= {function_key_source, virtual_output_source,
              indicator_source, virtual_input_source, digital_input_source};
      gs2 <= gs1;
      gs3 <= gs2;
      // accept a level only when the last two samples agree
      gsel <= (gs2 & gs3) | (gsel & (gs2 ^ gs3));
      active_setting_group <= next_group;
      min_line_voltage_readout <= prim(umin, scale);
      rdata <= rd ? next_rdata : 32'h00000000;
      if (force_on && tick) begin
        force_ms <= force_ms + 19'h1;
        if ({13'h0000, force_ms} == FORCE_MS - 32'h1) begin
          force_on <= 1'b0;
        end
      end
      if (wr && addr == `UVPS_A_PASS)
        auth <= (wdata == PASS_KEY);
      // a set written in the timeout cycle wins and restarts the count
      if (cfg_wr && addr == `UVPS_A_FORCE) begin
        force_on <= wdata[0];
        force_ms <= 19'h00000;
      end
      if (fval_wr) begin
        fstart <= wdata[2:0];
        ftrip <= wdata[5:3];
      end
      if (cfg_wr) begin
        case (addr)
          `UVPS_A_GRP: begin
            group_select_source <= wdata[2:0];
            manual_group <= wdata[5:4];
          end
          `UVPS_A_LOW_VOLTAGE_BLOCK_LIMIT: low_voltage_block_limit <= wdata[15:0];
          `UVPS_A_HYST:  hyst <= wdata[15:0];
          `UVPS_A_HOLD:  hold <= wdata[15:0];
          `UVPS_A_SCALE: scale <= wdata[15:0];
          default: begin
            for (k = 0; k < `UVPS_N_CFG; k = k + 1) begin
              if (addr == `UVPS_A_PICK + 8'h04 * k[7:0])
                pick[k] <= wdata[15:0];
              if (addr == `UVPS_A_DLY + 8'h04 * k[7:0])
                dly[k] <= wdata[15:0];
            end
          end
        endcase
      end
    end
  end

  // stage timers, outputs and event counters
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (n = 0; n < 3; n = n + 1) begin
        tmr[n] <= 16'h0000;
        start_event_count[n] <= 16'h0000;
        trip_event_count[n] <= 16'h0000;
      end
      hold_cnt <= 16'h0000;
      st_start <= 3'h0;
      st_trip <= 3'h0;
      start <= 3'h0;
      trip <= 3'h0;
    end else if (ce) begin
      if (cond[0]) begin
        hold_cnt <= hold;
      end else if (tick && hold_cnt != 16'h0000) begin
        hold_cnt <= hold_cnt - 16'h0001;
      end
      for (n = 0; n < 3; n = n + 1) begin
        if (cond[n]) begin
          st_start[n] <= 1'b1;
          if (tick && !expired[n])
            tmr[n] <= tmr[n] + 16'h0001;
          if (expired[n])
            st_trip[n] <= 1'b1;
        end else begin
          tmr[n] <= 16'h0000;
          // only the first stage keeps its outputs through the hold time
          if (n != 0 || hold_cnt == 16'h0000) begin
            st_start[n] <= 1'b0;
            st_trip[n] <= 1'b0;
          end
        end
        // a rising edge in the clear cycle still counts: set wins
        if (next_start[n] && !start[n]) begin
          start_event_count[n] <= (wr && addr == `UVPS_A_CNTCLR &&
                                   wdata[n]) ? 16'h0001 :
                                  start_event_count[n] + 16'h0001;
        end else if (wr && addr == `UVPS_A_CNTCLR && wdata[n]) begin
          start_event_count[n] <= 16'h0000;
        end
        if (next_trip[n] && !trip[n]) begin
          trip_event_count[n] <= (wr && addr == `UVPS_A_CNTCLR &&
                                  wdata[n+3]) ? 16'h0001 :
                                 trip_event_count[n] + 16'h0001;
        end else if (wr && addr == `UVPS_A_CNTCLR && wdata[n+3]) begin
          trip_event_count[n] <= 16'h0000;
        end
      end
      start <= next_start;
      trip <= next_trip;
    end
  end

endmodule // uvps_top

// file: src/uvps_map.vh
// register offsets, reset values and timing figures of the undervoltage block
`ifndef UVPS_MAP_VH
`define UVPS_MAP_VH
`define UVPS_CLK_HZ         40000000
`define UVPS_TICK_HZ        1000
`define UVPS_FORCE_MIN      5
`define UVPS_A_PASS         8'h00
`define UVPS_A_FORCE        8'h04
`define UVPS_A_FVAL         8'h08
`define UVPS_A_GRP          8'h0C
`define UVPS_A_LOW_VOLTAGE_BLOCK_LIMIT        8'h10
`define UVPS_A_HYST         8'h14
`define UVPS_A_HOLD         8'h18
`define UVPS_A_SCALE        8'h1C
`define UVPS_A_STATUS       8'h20
`define UVPS_A_MIN_LINE_VOLTAGE_READOUT         8'h24
`define UVPS_A_CNTCLR       8'h28
`define UVPS_A_SCNT         8'h30
`define UVPS_A_TCNT         8'h40
`define UVPS_A_PPRIM        8'h50
`define UVPS_A_PICK         8'h80
`define UVPS_A_DLY          8'hC0
`define UVPS_N_CFG          12
`define UVPS_RST_PICK       16'h0258
`define UVPS_RST_DLY        16'h01F4
`define UVPS_RST_LOW_VOLTAGE_BLOCK_LIMIT      16'h0096
`define UVPS_RST_HYST       16'h001E
`define UVPS_RST_HOLD       16'h0000
`define UVPS_RST_SCALE      16'h0040
`define UVPS_SRC_NONE       3'h0
`define UVPS_SRC_DI         3'h1
`define UVPS_SRC_VI         3'h2
`define UVPS_SRC_LED        3'h3
`define UVPS_SRC_VO         3'h4
`define UVPS_SRC_FK         3'h5
`define UVPS_ST_IDLE        2'h0
`define UVPS_ST_BLOCKED     2'h1
`define UVPS_ST_STARTED     2'h2
`define UVPS_ST_TRIPPED     2'h3
`endif

// file: tb/uvps_chk.sv
// port assertions for the undervoltage stages
module uvps_chk (
  input wire        clk,
  input wire        rstn,
  input wire [7:0]  addr,
  input wire        rd,
  input wire [31:0] rdata,
  input wire [15:0] u12,
  input wire [15:0] u23,
  input wire [15:0] u31,
  input wire [2:0]  block_in,
  input wire [2:0]  start,
  input wire [2:0]  trip,
  input wire [1:0]  active_setting_group
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire [15:0] m1   = (u12 < u23) ? u12 : u23;
  wire [15:0] umin = (m1 < u31) ? m1 : u31;
  property p_trip_after;
    (trip & ~$past(trip) & ~$past(start)) == 3'h0;
  endproperty
  a_trip_after: assert property (p_trip_after)
    else $error("trip rose without start");
  property p_trip_start;
    (trip[2:1] & ~start[2:1]) == 2'h0;
  endproperty
  a_trip_start: assert property (p_trip_start)
    else $error("trip without start");
  property p_release;
    $fell(start[1]) |-> !trip[1];
  endproperty
  a_release: assert property (p_release)
    else $error("stage two released apart");
  // stage two has no hold, so blocking must clear it in two edges
  property p_block;
    block_in[1] [*3] |-> !start[1] && !trip[1];
  endproperty
  a_block: assert property (p_block)
    else $error("blocked stage active");
  property p_st_trip;
    rd && addr == 8'h20 && trip[0] |=> rdata[1:0] == 2'h3;
  endproperty
  a_st_trip: assert property (p_st_trip)
    else $error("status not tripped");
  property p_st_start;
    rd && addr == 8'h20 && start[1] && !trip[1] |=> rdata[3:2] == 2'h2;
  endproperty
  a_st_start: assert property (p_st_start)
    else $error("status not started");
  property p_fval;
    rd && addr == 8'h08 |=> rdata[5:0] == {$past(trip), $past(start)};
  endproperty
  a_fval: assert property (p_fval)
    else $error("force value readback");
  // assumes the scale stays at its reset value
  property p_min_line_voltage_readout;
    rd && addr == 8'h24 && $stable(u12) && $stable(u23) && $stable(u31)
      |=> rdata == {16'h0000, $past(umin)} * 32'h00000040;
  endproperty
  a_min_line_voltage_readout: assert property (p_min_line_voltage_readout)
    else $error("minimum readout wrong");
  c_start: cover property ($rose(start[0]));
  c_trip: cover property ($rose(trip[0]));
  c_grp: cover property (active_setting_group == 2'h3);
endmodule // uvps_chk

// file: tb/uvps_front.sv
// measurement front end model feeding line voltages
module uvps_front (
  input  wire        clk,
  input  wire        rstn,
  input  wire [15:0] v12,
  input  wire [15:0] v23,
  input  wire [15:0] v31,
  output logic [15:0] u12,
  output logic [15:0] u23,
  output logic [15:0] u31
);
  timeunit 1ns;
  timeprecision 1ps;
  // one edge of latency, dead lines while in reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      u12 <= 16'h0000;
      u23 <= 16'h0000;
      u31 <= 16'h0000;
    end else begin
      u12 <= v12;
      u23 <= v23;
      u31 <= v31;
    end
  end
endmodule // uvps_front

// file: tb/tb_uvps_top.sv
// self-checking bench for the undervoltage stages
`include "uvps_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module tb_uvps_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] KEY = 32'h00005A5A; // arbitrary
  logic        clk = 0, rstn = 0, ce = 1, wr = 0, rd = 0, rd_q = 0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] v12 = 16'd1000, v23 = 16'd1000, v31 = 16'd1000;
  logic [15:0] u12, u23, u31, dip;
  logic [2:0]  block_in = 3'h0, start, trip;
  logic [1:0]  dis = 2'h1, vis = 2'h3, lds = 2'h0, vos = 2'h2, fks = 2'h1;
  logic [1:0]  grp;
  logic [1:0]  gexp [5] = '{2'h1, 2'h3, 2'h0, 2'h2, 2'h1};
  logic [63:0] q [$];
  logic [63:0] e;
  int          n_fail = 0, n_checks = 0, i;
  uvps_front uvps_front_i (.clk(clk), .rstn(rstn), .v12(v12), .v23(v23),
    .v31(v31), .u12(u12), .u23(u23), .u31(u31));
  uvps_top #(.MS_CYCLES(32'd4), .FORCE_MS(32'd10), .PASS_KEY(KEY))
    uvps_top_i (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .u12(u12),
    .u23(u23), .u31(u31), .block_in(block_in),
    .digital_input_source(dis), .virtual_input_source(vis),
    .indicator_source(lds), .virtual_output_source(vos),
    .function_key_source(fks), .start(start), .trip(trip),
    .active_setting_group(grp));
  initial forever #12.5 clk = ~clk;
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] x,
                      input logic [31:0] m = 32'h0000FFFF);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    q.push_back({m, x});
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic setv(input logic [15:0] a, input logic [15:0] b);
    @(posedge clk);
    v12 <= a;
    v23 <= b;
    v31 <= b;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      e = q.pop_front();
      `CHK(rdata & e[63:32], e[31:0])
    end
  end
  initial begin
    #(25 * 6000);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h3c688338));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rreg(8'h80, `UVPS_RST_PICK);
    rreg(8'hC0, `UVPS_RST_DLY);
    rreg(8'h10, `UVPS_RST_LOW_VOLTAGE_BLOCK_LIMIT);
    rreg(8'h14, `UVPS_RST_HYST);
    rreg(8'h18, `UVPS_RST_HOLD);
    rreg(8'h1C, `UVPS_RST_SCALE);
    rreg(8'hFC, 32'h0, 32'hFFFFFFFF);
    wreg(8'h10, 32'h0);
    rreg(8'h10, `UVPS_RST_LOW_VOLTAGE_BLOCK_LIMIT);
    wreg(8'h00, KEY);
    rreg(8'h00, 32'h1, 32'h1);
    wreg(8'hC0, 32'h3);
    dip = 16'd400 + 16'($urandom_range(149));
    setv(dip, 16'd1000);
    wt(5);
    `CHK(start, 3'h7)
    wt(24);
    `CHK(trip, 3'h1)
    rreg(8'h20, 32'h2B, 32'h3F);
    rreg(8'h24, {16'h0, dip} * 32'h40, 32'hFFFFFFFF);
    rreg(8'h50, 32'(`UVPS_RST_PICK) * `UVPS_RST_SCALE);
    rreg(8'h30, 32'h1);
    rreg(8'h40, 32'h1);
    rreg(8'h44, 32'h0);
    setv(16'd610, 16'd1000);
    wt(5);
    `CHK(start, 3'h7)
    setv(16'd640, 16'd1000);
    wt(5);
    `CHK({trip, start}, 6'h0)
    // short dips: a timer that never clears would add up to a trip
    for (i = 0; i < 3; i++) begin
      setv(dip, 16'd1000);
      wt(6);
      setv(16'd1000, 16'd1000);
      wt(4);
    end
    rreg(8'h40, 32'h1);
    wreg(8'h18, 32'h3);
    setv(dip, 16'd1000);
    wt(5);
    setv(16'd1000, 16'd1000);
    wt(4);
    `CHK(start, 3'h1)
    wt(20);
    `CHK(start, 3'h0)
    rreg(8'h30, 32'h5);
    wreg(8'h28, 32'h3F);
    rreg(8'h30, 32'h0);
    rreg(8'h40, 32'h0);
    @(posedge clk);
    block_in <= 3'h2;
    setv(dip, 16'd1000);
    wt(5);
    `CHK(start, 3'h5)
    setv(16'd1000, 16'd1000);
    wt(24);
    @(posedge clk);
    block_in <= 3'h0;
    setv(16'd100, 16'd100);
    wt(5);
    `CHK(start, 3'h0)
    wreg(8'h10, 32'h0);
    wt(5);
    `CHK(start, 3'h7)
    wreg(8'h10, `UVPS_RST_LOW_VOLTAGE_BLOCK_LIMIT);
    setv(16'd1000, 16'd1000);
    wt(24);
    wreg(8'h0C, 32'h20);
    wt(3);
    `CHK(grp, 2'h2)
    rreg(8'h0C, 32'h300, 32'h700);
    for (i = 1; i <= 5; i++) begin
      wreg(8'h0C, i);
      wt(8);
      `CHK(grp, gexp[i-1])
    end
    wreg(8'h08, 32'h7);
    wt(3);
    `CHK(start, 3'h0)
    wreg(8'h04, 32'h1);
    wreg(8'h08, 32'h7);
    wt(3);
    `CHK(start, 3'h7)
    rreg(8'h08, 32'h7, 32'h3F);
    wreg(8'h08, 32'h0);
    wt(50);
    wreg(8'h08, 32'h7);
    wt(3);
    `CHK(start, 3'h0)
    rreg(8'h04, 32'h0, 32'h1);
    // enable low must swallow an authorised write
    @(posedge clk);
    ce <= 1'b0;
    wreg(8'h18, 32'h5);
    ce <= 1'b1;
    rreg(8'h18, 32'h3);
    wt(3);
    tally_and_finish;
  end
endmodule // tb_uvps_top
bind uvps_top uvps_chk uvps_chk_i (.clk(clk), .rstn(rstn), .addr(addr),
  .rd(rd), .rdata(rdata), .u12(u12), .u23(u23), .u31(u31),
  .block_in(block_in), .start(start), .trip(trip),
  .active_setting_group(active_setting_group));
